// ===== src/lca_access.sv
// line card bus access logic: drawer ping-pong bus, line controls, axi regs
// assumes drawer pins are asynchronous and the drawer clock is far slower
//
// What this block does
// RULE1 - each bus transfer is exactly ten bits, PCM or signaling/control
// RULE2 - drawer sends an initialization bit, then a mode bit, then payload
// RULE3 - the mode bit chooses PCM sample or control data for the payload
// RULE4 - after ten received bits the bus turns round and the card drives
// RULE5 - card returns ten bits of PCM or signaling after the turnaround
// RULE6 - all bit timing follows the 2.56 MHz drawer clock
// RULE7 - hook and dial pulse state enter as digital supervision inputs
// RULE8 - signaling goes out only in the card's own control exchange
// RULE9 - a ringing control request operates the ringing relay driver
// RULE10 - while ringing, supervision feed is cut and ringing bus connected
// RULE11 - ring trip is reported during the silent interval of ringing
// RULE12 - receive loss for the d/a path is set by control data
// RULE13 - balance network selection is set by control data
// RULE14 - the card powers down while the line is idle
// RULE15 - loop-around code returns the received PCM byte unchanged
// RULE16 - test code drives the test access or cut-off relay driver
// RULE17 - balance selection appears on its own control output
// RULE18 - control settings hold until a later control sequence
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module lca_access (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    // drawer bus
    input wire logic bus_clk,
    input wire logic bus_din,
    output logic bus_dout,
    output logic bus_oe,
    // supervision network
    input wire logic hook_in,
    input wire logic ring_trip_in,
    input wire logic ring_silent_in,
    // codec side
    input wire logic [7:0] transmit_pcm_stream,
    output logic [7:0] received_pcm_stream,
    output logic received_pcm_valid,
    // line controls
    output logic ringing_relay,
    output logic feed_connect,
    output logic ringing_bus_connect,
    output logic test_access_relay,
    output logic cut_off_relay,
    output logic [2:0] loss_sel,
    output logic balance_net_sel,
    output logic ring_trip_output,
    output logic power_down
);
    // pin synchronisers: three stages, change taken when 2nd and 3rd agree
    logic [lca_pkg::NPIN-1:0] pin_raw;
    logic [lca_pkg::NPIN-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
    assign pin_raw = {ring_silent_in, ring_trip_in, hook_in, bus_din, bus_clk};
    genvar g;
    generate
        for (g = 0; g < lca_pkg::NPIN; g++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_reg[g] <= 1'h0;
                    s2_reg[g] <= 1'h0;
                    s3_reg[g] <= 1'h0;
                    pin_reg[g] <= 1'h0;
                end else begin
                    s1_reg[g] <= pin_raw[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) pin_reg[g] <= s3_reg[g]; // RULE7
                end
            end
        end
    endgenerate

    // drawer clock edges; the 40 MHz clock oversamples it about 15.6 times
    logic clk_prev_reg;
    logic rise, fall, din;
    assign rise = pin_reg[lca_pkg::P_CLK] & ~clk_prev_reg; // RULE6
    assign fall = ~pin_reg[lca_pkg::P_CLK] & clk_prev_reg; // RULE6
    assign din = pin_reg[lca_pkg::P_DAT];
    always_ff @(posedge aclk) begin
        if (!aresetn) clk_prev_reg <= 1'h0;
        else clk_prev_reg <= pin_reg[lca_pkg::P_CLK];
    end

    // software registers
    logic en_reg;
    logic [lca_pkg::EV_W-1:0] istat_reg, imask_reg, ev;
    logic [7:0] ctrl_byte_reg, tx_pcm_reg;
    logic rt_rep_reg, hook_prev_reg;

    // exchange engine
    lca_pkg::lca_state_e state_reg;
    logic [lca_pkg::CNT_W-1:0] cnt_reg;
    logic [lca_pkg::PAY_BITS:0] rx_sh_reg;
    logic [lca_pkg::SEQ_BITS-1:0] tx_sh_reg;
    logic [lca_pkg::PAY_BITS:0] rx_word;
    logic [7:0] pay, sig_byte;
    logic rx_done, rx_ctrl, tx_end;
    assign rx_word = {rx_sh_reg[lca_pkg::PAY_BITS-1:0], din};
    assign pay = rx_word[lca_pkg::PAY_BITS-1:0];
    assign rx_done = state_reg == lca_pkg::ST_RECV && rise
        && cnt_reg == lca_pkg::CNT_RX_LAST; // RULE1
    assign rx_ctrl = rx_word[lca_pkg::PAY_BITS] == lca_pkg::MODE_CTRL; // RULE3
    assign tx_end = state_reg == lca_pkg::ST_SEND && fall
        && cnt_reg == lca_pkg::CNT_TX_END; // RULE5
    assign sig_byte = {6'h00, rt_rep_reg, pin_reg[lca_pkg::P_HOOK]}; // RULE7

    // receive, turn round and send; disabled card never leaves idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= lca_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            rx_sh_reg <= 9'h000;
            tx_sh_reg <= 10'h000;
            bus_dout <= 1'h0;
            bus_oe <= 1'h0;
        end else begin
            unique case (state_reg)
                lca_pkg::ST_IDLE: begin
                    bus_oe <= 1'h0;
                    if (en_reg && rise && din) begin // RULE2
                        state_reg <= lca_pkg::ST_RECV;
                        cnt_reg <= lca_pkg::CNT_FIRST;
                    end
                end
                lca_pkg::ST_RECV: begin
                    if (rise) begin
                        rx_sh_reg <= rx_word;
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (rx_done) begin
                        state_reg <= lca_pkg::ST_TURN; // RULE4
                        if (rx_ctrl)
                            tx_sh_reg <= {lca_pkg::TX_START, 1'h1, sig_byte}; // RULE8
                        else if (ctrl_byte_reg[lca_pkg::CB_LOOP])
                            tx_sh_reg <= {lca_pkg::TX_START, 1'h0, pay}; // RULE15
                        else
                            tx_sh_reg <= {lca_pkg::TX_START, 1'h0, tx_pcm_reg};
                    end
                end
                lca_pkg::ST_TURN: begin
                    if (fall) begin // RULE4
                        bus_oe <= 1'h1;
                        bus_dout <= tx_sh_reg[lca_pkg::SEQ_BITS-1];
                        tx_sh_reg <= tx_sh_reg << 1;
                        cnt_reg <= lca_pkg::CNT_FIRST;
                        state_reg <= lca_pkg::ST_SEND;
                    end
                end
                lca_pkg::ST_SEND: begin
                    if (tx_end) begin
                        bus_oe <= 1'h0;
                        state_reg <= lca_pkg::ST_IDLE;
                    end else if (fall) begin // RULE5
                        bus_dout <= tx_sh_reg[lca_pkg::SEQ_BITS-1];
                        tx_sh_reg <= tx_sh_reg << 1;
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // control byte and received pcm; pcm exchanges leave settings alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_byte_reg <= 8'h00;
            received_pcm_stream <= 8'h00;
            received_pcm_valid <= 1'h0;
            tx_pcm_reg <= 8'h00;
        end else begin
            received_pcm_valid <= rx_done && !rx_ctrl;
            tx_pcm_reg <= transmit_pcm_stream;
            if (rx_done && rx_ctrl) ctrl_byte_reg <= pay; // RULE18
            if (rx_done && !rx_ctrl) received_pcm_stream <= pay; // RULE3
        end
    end

    // line control outputs follow the held control byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ringing_relay <= 1'h0;
            feed_connect <= 1'h1;
            ringing_bus_connect <= 1'h0;
            test_access_relay <= 1'h0;
            cut_off_relay <= 1'h0;
            loss_sel <= 3'h0;
            balance_net_sel <= 1'h0;
        end else begin
            ringing_relay <= ctrl_byte_reg[lca_pkg::CB_RING]; // RULE9
            feed_connect <= ~ctrl_byte_reg[lca_pkg::CB_RING]; // RULE10
            ringing_bus_connect <= ctrl_byte_reg[lca_pkg::CB_RING]; // RULE10
            test_access_relay <= ctrl_byte_reg[lca_pkg::CB_TA]; // RULE16
            cut_off_relay <= ctrl_byte_reg[lca_pkg::CB_CO]; // RULE16
            loss_sel <= ctrl_byte_reg[lca_pkg::CB_LOSS+:lca_pkg::LOSS_W]; // RULE12
            balance_net_sel <= ctrl_byte_reg[lca_pkg::CB_BAL]; // RULE13 RULE17
        end
    end

    // ring trip sampled only in silent gaps: the ringing burst itself
    // would swamp the loop current reading
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rt_rep_reg <= 1'h0;
            ring_trip_output <= 1'h0;
            hook_prev_reg <= 1'h0;
            power_down <= 1'h0;
        end else begin
            hook_prev_reg <= pin_reg[lca_pkg::P_HOOK];
            ring_trip_output <= rt_rep_reg;
            if (!ringing_relay) rt_rep_reg <= 1'h0;
            else if (pin_reg[lca_pkg::P_SIL])
                rt_rep_reg <= pin_reg[lca_pkg::P_RT]; // RULE11
            power_down <= ~pin_reg[lca_pkg::P_HOOK] & ~ringing_relay
                & ~test_access_relay & ~cut_off_relay; // RULE14
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    assign ev[lca_pkg::EV_CTRL] = rx_done && rx_ctrl;
    assign ev[lca_pkg::EV_HOOK] = pin_reg[lca_pkg::P_HOOK] ^ hook_prev_reg;
    assign ev[lca_pkg::EV_RTRIP] = rt_rep_reg & ~ring_trip_output;
    assign ev[lca_pkg::EV_DONE] = tx_end;

    // axi4-lite write side: address and data taken in either order
    logic aw_full_reg, w_full_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_wr, wb0;
    assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wb0 = wstrb_reg[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'h0;
            s_axi_wready <= 1'h0;
            aw_full_reg <= 1'h0;
            w_full_reg <= 1'h0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= lca_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'h0;
                aw_full_reg <= 1'h1;
                waddr_reg <= s_axi_awaddr;
            end else if (!aw_full_reg && !s_axi_bvalid)
                s_axi_awready <= 1'h1;
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'h0;
                w_full_reg <= 1'h1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (!w_full_reg && !s_axi_bvalid)
                s_axi_wready <= 1'h1;
            if (do_wr) begin
                aw_full_reg <= 1'h0;
                w_full_reg <= 1'h0;
                s_axi_bvalid <= 1'h1;
                unique case (waddr_reg)
                    lca_pkg::A_CTRL, lca_pkg::A_ISTAT, lca_pkg::A_IMASK,
                    lca_pkg::A_STATUS, lca_pkg::A_PCM:
                        s_axi_bresp <= lca_pkg::RESP_OKAY;
                    default: s_axi_bresp <= lca_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'h0;
        end
    end

    // writable registers and sticky status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_reg <= 1'h0;
            imask_reg <= 4'h0;
            istat_reg <= 4'h0;
            irq <= 1'h0;
        end else begin
            if (do_wr && wb0 && waddr_reg == lca_pkg::A_CTRL)
                en_reg <= wdata_reg[lca_pkg::CTRL_EN];
            if (do_wr && wb0 && waddr_reg == lca_pkg::A_IMASK)
                imask_reg <= wdata_reg[lca_pkg::EV_W-1:0];
            if (do_wr && wb0 && waddr_reg == lca_pkg::A_ISTAT)
                istat_reg <= (istat_reg & ~wdata_reg[lca_pkg::EV_W-1:0]) | ev;
            else
                istat_reg <= istat_reg | ev;
            irq <= |(istat_reg & imask_reg);
        end
    end

    // axi4-lite read side, answer one cycle after the address
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'h1;
        unique case (s_axi_araddr)
            lca_pkg::A_CTRL: rd_mux[lca_pkg::CTRL_EN] = en_reg;
            lca_pkg::A_STATUS: rd_mux = {19'h00000, state_reg, power_down,
                rt_rep_reg, pin_reg[lca_pkg::P_HOOK], ctrl_byte_reg};
            lca_pkg::A_ISTAT: rd_mux[lca_pkg::EV_W-1:0] = istat_reg;
            lca_pkg::A_IMASK: rd_mux[lca_pkg::EV_W-1:0] = imask_reg;
            lca_pkg::A_PCM: rd_mux = {16'h0000, tx_pcm_reg, received_pcm_stream};
            default: rd_ok = 1'h0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lca_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? lca_pkg::RESP_OKAY : lca_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
        end else if (!s_axi_rvalid)
            s_axi_arready <= 1'h1;
    end

    // checks on the exchange and the line controls
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rx_ctrl;
        rx_done && rx_ctrl;
    endsequence
    sequence s_rx_pcm;
        rx_done && !rx_ctrl;
    endsequence
    a_turn_after_ten: assert property (rx_done |=> state_reg == lca_pkg::ST_TURN
        && !bus_oe) else $error("no turnaround after ten bits"); // RULE4
    a_send_ten_bits: assert property ($fell(bus_oe) |->
        $past(cnt_reg) == lca_pkg::CNT_TX_END) else $error("send not ten"); // RULE5
    a_ctrl_latch: assert property (s_rx_ctrl |=> ctrl_byte_reg == $past(pay))
        else $error("control byte not taken"); // RULE3
    a_ctrl_held: assert property (s_rx_pcm |=> $stable(ctrl_byte_reg))
        else $error("pcm changed control"); // RULE18
    a_sig_slot: assert property (s_rx_pcm |=> !tx_sh_reg[lca_pkg::PAY_BITS])
        else $error("signaling outside own slot"); // RULE8
    a_loop_back: assert property (s_rx_pcm ##0 ctrl_byte_reg[lca_pkg::CB_LOOP]
        |=> tx_sh_reg[7:0] == $past(pay)) else $error("loop byte"); // RULE15
    a_ring_relay: assert property (s_rx_ctrl ##0 pay[lca_pkg::CB_RING]
        |-> ##2 ringing_relay) else $error("ring request ignored"); // RULE9
    a_ring_feed: assert property (ringing_relay |-> !feed_connect
        && ringing_bus_connect) else $error("feed not cut"); // RULE10
    a_ring_power: assert property (ringing_relay |=> !power_down)
        else $error("power down while ringing"); // RULE14
    a_trip_gap: assert property (!ringing_relay |=> !rt_rep_reg)
        else $error("trip without ringing"); // RULE11
    a_bal_out: assert property (s_rx_ctrl |-> ##2
        balance_net_sel == $past(pay[lca_pkg::CB_BAL], 2)) else $error("bal"); // RULE17
    // seven cycles is HALF_BIT_CYC, the 2.56 MHz half period; the synchronisers follow levels held two cycles
    a_edge_gap: assert property (rise |-> !fall [*7])
        else $error("drawer clock too fast"); // RULE6
endmodule // lca_access

// ===== src/lca_pkg.sv
// constants shared by the line card bus access logic
// assumes one 40 MHz system clock; drawer pins pass through three-stage synchronisers
package lca_pkg;
    // exchange format on the drawer bus
    localparam int SEQ_BITS = 10;
    localparam int PAY_BITS = 8;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_FIRST = 4'h1;
    localparam logic [CNT_W-1:0] CNT_RX_LAST = 4'h9;
    localparam logic [CNT_W-1:0] CNT_TX_END = 4'ha;
    localparam logic MODE_CTRL = 1'h1;
    localparam logic TX_START = 1'h1;
    // rates: drawer bit clock against system clock
    localparam int CLK_KHZ = 40000;
    localparam int BUS_CLK_KHZ = 2560;
    localparam int HALF_BIT_CYC = CLK_KHZ / (2 * BUS_CLK_KHZ);
    // control byte fields
    localparam int CB_RING = 0;
    localparam int CB_TA = 1;
    localparam int CB_CO = 2;
    localparam int CB_LOOP = 3;
    localparam int CB_BAL = 4;
    localparam int CB_LOSS = 5;
    localparam int LOSS_W = 3;
    // signaling byte fields
    localparam int SB_HOOK = 0;
    localparam int SB_RTRIP = 1;
    // synchronised pins
    localparam int P_CLK = 0;
    localparam int P_DAT = 1;
    localparam int P_HOOK = 2;
    localparam int P_RT = 3;
    localparam int P_SIL = 4;
    localparam int NPIN = 5;
    // register map, byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_ISTAT = 8'h08;
    localparam logic [7:0] A_IMASK = 8'h0c;
    localparam logic [7:0] A_PCM = 8'h10;
    localparam int CTRL_EN = 0;
    // interrupt events
    localparam int EV_CTRL = 0;
    localparam int EV_HOOK = 1;
    localparam int EV_RTRIP = 2;
    localparam int EV_DONE = 3;
    localparam int EV_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_TURN, ST_SEND} lca_state_e;
endpackage

// ===== test/lca_access_tb.sv
// bench for lca_access: axi registers, irq, drawer exchanges, controls
// assumes the drawer model on the bus pins and a fixed random seed
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("ERROR %s exp %0h got %0h", n, e, g); \
    end \
end
module lca_access_tb;
    // design pins
    logic aclk = 1'b0, aresetn = 1'b0, irq;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hook_in = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, bus_clk, bus_din, bus_dout, bus_oe;
    logic ring_trip_in = 1'b0, ring_silent_in = 1'b0;
    logic [7:0] transmit_pcm_stream = 8'h0, received_pcm_stream;
    logic received_pcm_valid, ringing_relay, feed_connect;
    logic ringing_bus_connect, test_access_relay, cut_off_relay;
    logic balance_net_sel, ring_trip_output, power_down;
    logic [2:0] loss_sel;
    int error_cnt = 0, checked = 0, cyc = 0, pcm_pulses = 0;
    // count the one-cycle pulses that mark each received pcm byte
    always @(posedge aclk) begin
        if (received_pcm_valid === 1'b1) pcm_pulses++;
    end
    always #12.5 aclk = ~aclk;
    lca_access DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irq, .bus_clk, .bus_din, .bus_dout, .bus_oe,
        .hook_in, .ring_trip_in, .ring_silent_in, .transmit_pcm_stream,
        .received_pcm_stream, .received_pcm_valid, .ringing_relay,
        .feed_connect, .ringing_bus_connect, .test_access_relay,
        .cut_off_relay, .loss_sel, .balance_net_sel, .ring_trip_output,
        .power_down);
    lca_drawer DRAWER (.aclk, .bus_clk, .bus_din, .bus_dout, .bus_oe);
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one write; ends an edge later so the next task never re-drives
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er = lca_pkg::RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
        @(posedge aclk);
    endtask
    // one read, compared against the expected word and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er = lca_pkg::RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", e, s_axi_rdata)
        @(posedge aclk);
    endtask
    // full exchange, then the card must have let go of the line
    task automatic xchg(input logic m, input logic [7:0] b,
            input logic [9:0] e);
        logic [9:0] got;
        DRAWER.exchange({1'b1, m, b}, got);
        `CHK("return word", e, got)
        repeat (4) @(posedge aclk);
        `CHK("bus_oe", 1'b0, bus_oe)
    endtask
    // control exchange and the line controls it must leave behind
    task automatic ctl(input logic [7:0] b, input logic rt);
        xchg(lca_pkg::MODE_CTRL, b, {2'b11, 6'h0, rt, hook_in});
        `CHK("ringing_relay", b[0], ringing_relay)
        `CHK("feed/ring bus", {~b[0], b[0]}, {feed_connect, ringing_bus_connect})
        `CHK("co/ta", b[2:1], {cut_off_relay, test_access_relay})
        `CHK("loss_sel", b[7:5], loss_sel)
        `CHK("balance", b[4], balance_net_sel)
        `CHK("power_down", ~(hook_in | (|b[2:0])), power_down)
    endtask
    initial begin
        logic [9:0] got;
        logic [7:0] b;
        logic [7:0] x;
        void'($urandom(48275));
        repeat (6) @(posedge aclk);
        `CHK("reset levels", 2'b10, {feed_connect, ringing_relay})
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        `CHK("idle power_down", 1'b1, power_down)
        // a disabled card ignores the init bit and never drives
        DRAWER.exchange(10'h3ff, got);
        `CHK("disabled return", 10'h0, got)
        wr(lca_pkg::A_CTRL, 32'h1);
        rd(lca_pkg::A_CTRL, 32'h1);
        wr(8'h20, 32'h5, lca_pkg::RESP_SLVERR);
        rd(8'h20, 32'h0, lca_pkg::RESP_SLVERR);
        wr(lca_pkg::A_IMASK, 32'h1);
        rd(lca_pkg::A_IMASK, 32'h1);
        // all-ones and all-zeros corners first, then random bytes
        for (int i = 0; i < 8; i++) begin
            b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            hook_in <= 1'($urandom);
            repeat (12) @(posedge aclk);
            wr(lca_pkg::A_ISTAT, 32'hf);
            ctl(b, 1'b0);
            rd(lca_pkg::A_STATUS, {21'h0, ~(hook_in | (|b[2:0])),
                1'b0, hook_in, b});
            rd(lca_pkg::A_ISTAT, 32'h9);
            `CHK("irq", 1'b1, irq)
            wr(lca_pkg::A_ISTAT, 32'h1);
            repeat (2) @(posedge aclk);
            `CHK("irq cleared", 1'b0, irq)
        end
        // pcm straight through, then looped back from the fifth on
        ctl(8'h00, 1'b0);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                ctl(8'h08, 1'b0);
            end
            x = 8'($urandom);
            b = 8'($urandom);
            transmit_pcm_stream <= x;
            xchg(1'b0, b, {2'b10, (i < 4) ? x : b});
            `CHK("rx pcm", b, received_pcm_stream)
            `CHK("held loss", 3'h0, loss_sel)
        end
        `CHK("pcm pulses", 8, pcm_pulses)
        // trip seen during the silent interval while ringing
        ctl(8'h01, 1'b0);
        ring_silent_in <= 1'b1;
        ring_trip_in <= 1'b1;
        repeat (20) @(posedge aclk);
        `CHK("ring_trip_output", 1'b1, ring_trip_output)
        rd(lca_pkg::A_ISTAT, 32'hd);
        ctl(8'h01, 1'b1);
        summarize();
    end
endmodule // lca_access_tb

// ===== test/lca_drawer.sv
// drawer-side bus model: bit clock, init/mode/payload out, ten bits back
// assumes the 40 MHz aclk; the line idles low through a pull-down
`timescale 1ns/1ps
module lca_drawer (
    // timing reference
    input wire logic aclk,
    // drawer bus
    output logic bus_clk,
    output logic bus_din,
    input wire logic bus_dout,
    input wire logic bus_oe
);
    // a half bit is 7.8 aclk cycles; 8 gives 2.5 MHz, the nearest whole rate
    localparam int H = lca_pkg::HALF_BIT_CYC + 1;
    logic drv_en = 1'b0;
    logic drv_bit = 1'b0;
    // pull-down wins when nobody drives, so no stale level lingers
    assign bus_din = bus_oe ? bus_dout : (drv_en & drv_bit);
    // bit clock stands low between frames
    initial bus_clk = 1'b0;
    // ten bits sent on rises, release, ten bits sampled on rises
    task automatic exchange(input logic [9:0] tx, output logic [9:0] rx);
        drv_en <= 1'b1;
        for (int i = 9; i >= 0; i--) begin
            drv_bit <= tx[i];
            repeat (H) @(posedge aclk);
            bus_clk <= 1'b1;
            repeat (H) @(posedge aclk);
            bus_clk <= 1'b0;
        end
        drv_en <= 1'b0;
        for (int i = 9; i >= 0; i--) begin
            repeat (H) @(posedge aclk);
            bus_clk <= 1'b1;
            rx[i] = bus_din;
            repeat (H) @(posedge aclk);
            bus_clk <= 1'b0;
        end
        repeat (H) @(posedge aclk);
    endtask
endmodule // lca_drawer
